// file: design/core_consts.vh
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH
// instruction cycle timing
`define CLK_NS 10
`define CYC_NS 250
`define CYC_CLKS (`CYC_NS / `CLK_NS)
`define Q2_AT (`CYC_CLKS / 4)
`define Q3_AT (`CYC_CLKS / 2)
`define Q4_AT ((3 * `CYC_CLKS) / 4)
`define PH_LAST (`CYC_CLKS - 1)
// instruction fields
`define F_OP 15:13
`define F_SPORT 12
`define F_SREG 11:9
`define F_SBANK 9
`define F_ROT 8:6
`define F_DPORT 5
`define F_DREG 4:2
`define F_DBANK 4
`define F_SHIFT 3:2
`define F_LEN 1:0
`define F_IMM 12:5
`define F_LOW 4:0
`define F_HOLD 5
`define F_XPORT 1
`define F_XBANK 0
// operation codes, aux register index and reset values
`define OP_MOVE 3'h0
`define OP_ADD 3'h1
`define OP_AND 3'h2
`define OP_XOR 3'h3
`define OP_XMIT 3'h4
`define OP_CBR 3'h5
`define OP_JMP 3'h6
`define OP_SEL 3'h7
`define AUX_IDX 3'h0
`define PC_RST 13'h1fff
`define IR_RST 16'h0000
// register map
`define RA_CTRL 8'h00
`define RA_STAT 8'h04
`define RA_SEL 8'h08
`define RA_AUX 8'h0c
`define CTRL_RST 1'b0
`endif

// file: design/io_core.v
`timescale 1ns/10ps
`include "core_consts.vh"

module io_core (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire [15:0] instr_data_in,
   output wire [12:0] instruction_address_lines,
   input wire [7:0] interface_vector_bus_in,
   output wire [7:0] interface_vector_bus_out,
   output wire interface_vector_bus_oe_n,
   output wire left_bank_enable,
   output wire right_bank_enable,
   output wire write_control,
   output wire select_control,
   output wire master_clock
);

localparam integer PH_Q2 = `Q2_AT;
localparam integer PH_Q3 = `Q3_AT;
localparam integer PH_Q4 = `Q4_AT;
localparam integer PH_LAST = `PH_LAST;

function [7:0] rotr;
   input [7:0] v;
   input [2:0] n;
   begin
      rotr = (v >> n) | (v << (4'h8 - {1'b0, n}));
   end
endfunction

function [7:0] lenmask;
   input [1:0] c;
   begin
      lenmask = 8'hff >> {c, 1'b0} >> (c == 2'h3 ? 1 : 0);
   end
endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [15:0] instr_m_q, instr_s_q;
reg [7:0] iv_m_q, iv_s_q;

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      instr_m_q <= 16'h0000;
      instr_s_q <= 16'h0000;
      iv_m_q <= 8'h00;
      iv_s_q <= 8'h00;
   end else begin
      instr_m_q <= instr_data_in;
      instr_s_q <= instr_m_q;
      iv_m_q <= interface_vector_bus_in;
      iv_s_q <= iv_m_q;
   end
end

////////////////////////////////////////////////////////////////////////
// core state
reg [4:0] phase_q;
reg run_q;
reg [15:0] ir_q;
reg [12:0] cur_pc_q, addr_q;
reg [7:0] rf_q [0:7];
reg ovf_q;
reg [7:0] in_q;
reg [7:0] sel_l_q, sel_r_q;
reg [7:0] iv_out_q;
reg iv_oe_n_q, lb_q, rb_q, wc_q, sc_q, mclk_q;
integer i;

wire [2:0] op = ir_q[`F_OP];
wire src_port = ir_q[`F_SPORT] && op != `OP_XMIT;
wire [7:0] src_val = src_port ? in_q : rf_q[ir_q[`F_SREG]];
wire [7:0] msk = lenmask(ir_q[`F_LEN]);
wire [7:0] opnd = rotr(src_val, ir_q[`F_ROT]) & msk;
wire [7:0] aux = rf_q[`AUX_IDX];
wire [8:0] sum = {1'b0, aux} + {1'b0, opnd};
wire is_data = op <= `OP_XOR;
wire dst_port = is_data ? ir_q[`F_DPORT] : (op == `OP_XMIT && ir_q[`F_XPORT]);
wire dst_bank = is_data ? ir_q[`F_DBANK] : ir_q[`F_XBANK];
wire [2:0] shamt = is_data ? {1'b0, ir_q[`F_SHIFT]} : 3'h0;
wire [7:0] fmask = (op == `OP_XMIT ? 8'hff : msk) << shamt;
reg [7:0] res;
reg [12:0] next_pc;

always @* begin
   case (op)
      `OP_ADD: res = sum[7:0];
      `OP_AND: res = aux & opnd;
      `OP_XOR: res = aux ^ opnd;
      `OP_XMIT: res = ir_q[`F_IMM];
      default: res = opnd;
   endcase
end

// hazard: merge reuses the byte latched in q2, so a partial write keeps the source port's other bits
wire [7:0] port_byte = ((res << shamt) & fmask) | (in_q & ~fmask);

always @* begin
   case (op)
      `OP_CBR: next_pc = {opnd, ir_q[`F_LOW]};
      `OP_JMP: next_pc = ir_q[`F_HOLD] ? cur_pc_q : {cur_pc_q[12:5], ir_q[`F_LOW]};
      default: next_pc = cur_pc_q + 13'h0001;
   endcase
end

////////////////////////////////////////////////////////////////////////
// instruction cycle sequencer
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      phase_q <= 5'h00;
      ir_q <= `IR_RST;
      cur_pc_q <= `PC_RST;
      addr_q <= `PC_RST;
      ovf_q <= 1'b0;
      in_q <= 8'h00;
      sel_l_q <= 8'h00;
      sel_r_q <= 8'h00;
      iv_out_q <= 8'h00;
      iv_oe_n_q <= 1'b1;
      lb_q <= 1'b1;
      rb_q <= 1'b0;
      wc_q <= 1'b0;
      sc_q <= 1'b0;
      mclk_q <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         rf_q[i] <= 8'h00;
      end
   end else if (run_q) begin
      phase_q <= (phase_q == PH_LAST) ? 5'h00 : phase_q + 5'h01;
      if (phase_q == 5'h00) begin
         mclk_q <= 1'b1;
      end
      if (phase_q == PH_Q2) begin
         in_q <= iv_s_q;
      end
      if (phase_q == PH_Q3) begin
         mclk_q <= 1'b0;
         addr_q <= next_pc;
         lb_q <= (op == `OP_SEL) ? !ir_q[`F_XBANK] : !dst_bank;
         rb_q <= (op == `OP_SEL) ? ir_q[`F_XBANK] : dst_bank;
         if (op == `OP_SEL) begin
            iv_out_q <= ir_q[`F_IMM];
            iv_oe_n_q <= 1'b0;
            if (ir_q[`F_XBANK]) begin
               sel_r_q <= ir_q[`F_IMM];
            end else begin
               sel_l_q <= ir_q[`F_IMM];
            end
         end else if (dst_port) begin
            iv_out_q <= port_byte;
            iv_oe_n_q <= 1'b0;
         end else if (is_data || op == `OP_XMIT) begin
            rf_q[is_data ? ir_q[`F_DREG] : ir_q[`F_DREG]] <= res;
         end
         if (op == `OP_ADD) begin
            ovf_q <= sum[8];
         end
      end
      if (phase_q == PH_Q4) begin
         sc_q <= (op == `OP_SEL);
         wc_q <= dst_port;
      end
      if (phase_q == PH_LAST) begin
         wc_q <= 1'b0;
         sc_q <= 1'b0;
         iv_oe_n_q <= 1'b1;
         ir_q <= instr_s_q;
         cur_pc_q <= addr_q;
         lb_q <= !instr_s_q[`F_SBANK];
         rb_q <= instr_s_q[`F_SBANK];
      end
   end
end

////////////////////////////////////////////////////////////////////////
// ahb-lite register slave, zero wait states
reg [7:0] wa_q;
reg wr_pend_q;
reg [31:0] hrdata_q;
reg hreadyout_q;
reg hresp_q;
wire take = hsel && hready && htrans[1];

function [31:0] rd_mux;
   input [7:0] a;
   begin
      case (a)
         `RA_CTRL: rd_mux = {31'h0, run_q};
         `RA_STAT: rd_mux = {2'h0, cur_pc_q, addr_q, 3'h0, ovf_q};
         `RA_SEL: rd_mux = {16'h0, sel_r_q, sel_l_q};
         `RA_AUX: rd_mux = {16'h0, rf_q[7], rf_q[`AUX_IDX]};
         default: rd_mux = 32'h0;
      endcase
   end
endfunction

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wa_q <= 8'h00;
      wr_pend_q <= 1'b0;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      run_q <= `CTRL_RST;
   end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= take && hwrite;
      if (take) begin
         wa_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
         hrdata_q <= rd_mux(haddr[7:0]);
      end
      if (wr_pend_q && wa_q == `RA_CTRL) begin
         run_q <= hwdata[0];
      end
   end
end

assign hrdata = hrdata_q;
assign hreadyout = hreadyout_q;
assign hresp = hresp_q;
assign instruction_address_lines = addr_q;
assign interface_vector_bus_out = iv_out_q;
assign interface_vector_bus_oe_n = iv_oe_n_q;
assign left_bank_enable = lb_q;
assign right_bank_enable = rb_q;
assign write_control = wc_q;
assign select_control = sc_q;
assign master_clock = mclk_q;

endmodule // io_core

// file: dv/io_core_assertions.sv
`timescale 1ns/10ps
module io_core_chk (
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   input wire [12:0] instruction_address_lines,
   input wire interface_vector_bus_oe_n,
   input wire left_bank_enable,
   input wire right_bank_enable,
   input wire write_control,
   input wire select_control,
   input wire master_clock
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // quarters are rounded down to six clocks
   sequence quarter_of(s);
      s [*6] ##1 !s;
   endsequence
   sequence one_cycle;
      master_clock [*8] ##5 !master_clock ##13 $rose(master_clock);
   endsequence
   zero_wait_a: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   banks_complement_a: assert property (left_bank_enable != right_bank_enable)
      else $error("bank lines not complementary");
   one_strobe_a: assert property (!(write_control && select_control))
      else $error("two strobes at once");
   drive_on_strobe_a: assert property ((write_control || select_control) |-> !interface_vector_bus_oe_n)
      else $error("strobe without bus drive");
   write_quarter_a: assert property ($rose(write_control) |-> quarter_of(write_control))
      else $error("write strobe width");
   select_quarter_a: assert property ($rose(select_control) |-> quarter_of(select_control))
      else $error("select strobe width");
   cycle_250ns_a: assert property ($rose(master_clock) |-> one_cycle)
      else $error("cycle length");
   addr_in_q3_a: assert property ($changed(instruction_address_lines) |-> $fell(master_clock))
      else $error("address out of third quarter");
   // source bank moves at the cycle boundary, one clock before master clock rises
   bank_edges_a: assert property ($changed(left_bank_enable) |-> $fell(master_clock) or ##1 $rose(master_clock))
      else $error("bank change off quarter edge");
endmodule // io_core_chk
bind io_core io_core_chk u_io_core_chk (.hclk, .hresetn, .hreadyout, .hresp, .instruction_address_lines,
   .interface_vector_bus_oe_n, .left_bank_enable, .right_bank_enable, .write_control, .select_control,
   .master_clock);

// file: dv/port_latches.sv
`timescale 1ns/10ps
module port_latches (
   input wire hclk,
   input wire [7:0] bus_out,
   input wire bus_oe_n,
   input wire left_bank_enable,
   input wire right_bank_enable,
   input wire write_control,
   input wire select_control,
   output logic [7:0] bus_in = 8'h00
);
   logic [7:0] latch_q [512];
   logic [7:0] sel_q [2];
   logic [1:0] valid_q = 2'b00;
   wire bank = right_bank_enable & !left_bank_enable;
   // no fetch-time address field: ports are chosen by select cycles only
   always @(posedge hclk) begin
      if (select_control) begin
         sel_q[bank] <= bus_out;
         valid_q[bank] <= 1'b1;
      end
      if (write_control && valid_q[bank])
         latch_q[{bank, sel_q[bank]}] <= bus_out;
      // nobody selected: toggle so a stale byte is never mistaken for data
      if (!bus_oe_n)
         bus_in <= bus_out;
      else if (valid_q[bank])
         bus_in <= latch_q[{bank, sel_q[bank]}];
      else
         bus_in <= ~bus_in;
   end
endmodule // port_latches

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {logic [31:0] a; logic [31:0] wd; logic wr; logic [31:0] exp;} row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] instr_data_in = 16'h0000;
   wire [31:0] hrdata;
   wire hreadyout, hresp, bus_oe_n, left_bank_enable, right_bank_enable, write_control, select_control, master_clock;
   wire [12:0] instruction_address_lines;
   wire [7:0] bus_in, bus_out;
   logic [15:0] rom [8] = '{16'he780, 16'hf861, 16'h94a2, 16'h1030, 16'h1200, 16'h205c, 16'hc020, 16'h0000};
   row_t rows [5] = '{'{32'h0, 32'h0, 1'b0, 32'h0}, '{32'h40, 32'hffffffff, 1'b1, 32'h0},
      '{32'h40, 32'h0, 1'b0, 32'h0}, '{32'h0, 32'h1, 1'b1, 32'h0}, '{32'h0, 32'h0, 1'b0, 32'h1}};
   logic [31:0] rd;
   int num_errors = 0;
   int samples_checked = 0;
   io_core u_io_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .instr_data_in, .instruction_address_lines, .interface_vector_bus_in(bus_in),
      .interface_vector_bus_out(bus_out), .interface_vector_bus_oe_n(bus_oe_n), .left_bank_enable,
      .right_bank_enable, .write_control, .select_control, .master_clock);
   port_latches u_port_latches (.hclk, .bus_out, .bus_oe_n, .left_bank_enable, .right_bank_enable,
      .write_control, .select_control, .bus_in);
   always #5 hclk = ~hclk;
   always @(posedge hclk) instr_data_in <= rom[instruction_address_lines[2:0]] & {16{instruction_address_lines < 13'h8}};
   ////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ready and read data are taken at the rising edge, before that edge's updates land
   task automatic ready(output logic [31:0] d);
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask
   task automatic bus(input logic [31:0] a, input logic [31:0] wd, input logic wr, output logic [31:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
      ready(d);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      ready(d);
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         bus(rows[i].a, rows[i].wd, rows[i].wr, rd);
         if (!rows[i].wr) chk(rd, rows[i].exp);
      end
      repeat (300) @(posedge hclk);
      bus(32'h0c, 32'h0, 1'b0, rd);
      chk(rd, 32'h000077a5);
      bus(32'h04, 32'h0, 1'b0, rd);
      chk(rd, 32'h000c0061);
      hresetn <= 1'b0;
      @(negedge hclk);
      chk({19'h0, instruction_address_lines}, 32'h1fff);
      chk({26'h0, bus_oe_n, left_bank_enable, right_bank_enable, write_control, select_control, master_clock}, 32'h30);
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(32'h0, 32'h0, 1'b0, rd);
      chk(rd, 32'h0);
      summarize();
   end
   initial begin
      repeat (2000) @(posedge hclk);
      num_errors++;
      summarize();
   end
endmodule // tb_top
